// *** pkg/eepwp_pkg.sv ***
// constants and types shared by both ends of the two-wire eeprom link
// ============================================================
package eepwp_pkg;
  // ============================================================
  // bus constants
  localparam logic [6:0] EEPWP_TARGET_ADDR = 7'h50;
  localparam logic EEPWP_DIR_READ = 1'h1;
  localparam logic EEPWP_DIR_WRITE = 1'h0;
  localparam int EEPWP_ADDR_W = 8;
  localparam int EEPWP_DEPTH = 256;
  localparam logic [7:0] EEPWP_PTR_RESET = 8'h00;
  // scl half period in system clocks for the master divider
  localparam int EEPWP_CLK_HZ = 40000000;
  localparam int EEPWP_SCL_HZ = 400000;
  localparam int EEPWP_HALF_CYC = EEPWP_CLK_HZ / (2 * EEPWP_SCL_HZ);
  localparam logic [3:0] EEPWP_BIT_LAST = 4'h8;

  // master request kinds
  typedef enum logic [1:0]
  {
    EEPWP_OP_CUR = 2'b00,
    EEPWP_OP_RAND = 2'b01,
    EEPWP_OP_WRITE = 2'b10
  } eepwp_op_t;
endpackage

// *** pkg/eepwp_if.sv ***
// two-wire link between the eeprom target and the bus master
`timescale 1ns/100ps
`default_nettype none
interface eepwp_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // open drain wire level with pull-up
  wire logic scl = scl_oe ? scl_o : 1'b1;
  wire logic sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
  modport target (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o,
    output sda_m_oe);
endinterface
`default_nettype wire

// *** src/eepwp_target.sv ***
// two-wire eeprom target with auto-increment counter and write protect
`timescale 1ns/100ps
`default_nettype none
module eepwp_target
  #(parameter int DEPTH = eepwp_pkg::EEPWP_DEPTH)
  (
    input wire logic clk_sys,
    input wire logic rst_b,
    eepwp_if.target bus,
    input wire logic wp_pin,
    output logic busy_prog
  );
  import eepwp_pkg::*;

  typedef enum logic [2:0]
  {
    T_IDLE = 3'b000,
    T_DEV = 3'b001,
    T_WADDR = 3'b010,
    T_WDATA = 3'b011,
    T_RDATA = 3'b100,
    T_WAITSTOP = 3'b101
  } eepwp_tst_t;

  typedef struct packed
  {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic wp_s1;
    logic wp_s2;
    logic scl_p;
    logic sda_p;
    eepwp_tst_t st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic in_ack;
    logic sda_drv;
    logic wr_ok;
    logic prog;
  } eepwp_tstate_t;

  eepwp_tstate_t s_q, s_d;
  logic [7:0] mem_q [DEPTH];
  logic mem_we;
  logic scl_r, scl_f, start_c, stop_c;

  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = s_q.sda_drv;
  assign busy_prog = s_q.prog;

  // array storage, written one byte per acked data byte
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
    begin
      mem_q[s_q.ptr] <= {s_q.sh[6:0], s_q.sda_p};
    end
  end

  // edge and condition detect on the synchronised lines
  always_comb
  begin
    scl_r = s_q.scl_s[1] & ~s_q.scl_p;
    scl_f = ~s_q.scl_s[1] & s_q.scl_p;
    start_c = s_q.scl_s[1] & s_q.scl_p & s_q.sda_p & ~s_q.sda_s[1];
    stop_c = s_q.scl_s[1] & s_q.scl_p & ~s_q.sda_p & s_q.sda_s[1];
  end

  // protocol engine, acts on scl edges
  always_comb
  begin
    s_d = s_q;
    mem_we = 1'b0;
    s_d.scl_s = {s_q.scl_s[0], bus.scl};
    s_d.sda_s = {s_q.sda_s[0], bus.sda};
    s_d.wp_s1 = wp_pin;
    s_d.wp_s2 = s_q.wp_s1;
    s_d.scl_p = s_q.scl_s[1];
    s_d.sda_p = s_q.sda_s[1];
    if (stop_c)
    begin
      s_d.st = T_IDLE;
      s_d.sda_drv = 1'b0;
      s_d.prog = 1'b0;
    end
    else if (start_c)
    begin
      s_d.st = T_DEV;
      s_d.bitn = 4'h0;
      s_d.in_ack = 1'b0;
      s_d.sda_drv = 1'b0;
    end
    else if (s_q.st != T_IDLE && s_q.st != T_WAITSTOP)
    begin
      if (scl_r && !s_q.in_ack)
      begin
        s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
        s_d.bitn = s_q.bitn + 4'h1;
      end
      else if (scl_r && s_q.in_ack && s_q.st == T_RDATA && !s_q.sda_drv) // own ack clock skipped
      begin
        // master ack asks for next byte, nack ends the read
        if (s_q.sda_s[1])
        begin
          s_d.st = T_WAITSTOP;
        end
        else
        begin
          s_d.sh = mem_q[s_q.ptr];
          s_d.ptr = s_q.ptr + 8'h01;
        end
      end
      if (scl_f && s_q.in_ack)
      begin
        // end of ack clock, release line (or drive first bit of next read byte) and begin next byte
        s_d.in_ack = 1'b0;
        s_d.bitn = 4'h0;
        s_d.sda_drv = (s_q.st == T_RDATA) ? ~s_q.sh[7] : 1'b0;
      end
      else if (scl_f && s_q.bitn == EEPWP_BIT_LAST)
      begin
        s_d.in_ack = 1'b1;
        s_d.sda_drv = 1'b0;
        unique case (s_q.st)
          T_DEV:
          begin
            if (s_q.sh[7:1] == EEPWP_TARGET_ADDR)
            begin
              s_d.sda_drv = 1'b1;
              if (s_q.sh[0] == EEPWP_DIR_READ)
              begin
                s_d.st = T_RDATA;
                s_d.sh = mem_q[s_q.ptr];
                s_d.ptr = s_q.ptr + 8'h01;
              end
              else
              begin
                s_d.st = T_WADDR;
              end
            end
            else
            begin
              s_d.st = T_WAITSTOP;
            end
          end
          T_WADDR:
          begin
            s_d.sda_drv = 1'b1;
            s_d.ptr = s_q.sh;
            s_d.wr_ok = 1'b0;
            s_d.st = T_WDATA;
          end
          T_WDATA:
          begin
            if (s_q.wp_s2)
            begin
              s_d.st = T_WAITSTOP;
            end
            else
            begin
              s_d.sda_drv = 1'b1;
              s_d.wr_ok = 1'b1;
              s_d.ptr = s_q.ptr + 8'h01;
            end
          end
          T_RDATA:
          begin
            s_d.sda_drv = 1'b0;
          end
          default:
          begin
            s_d.st = T_WAITSTOP;
          end
        endcase
      end
      else if (scl_f && s_q.st == T_RDATA && !s_q.in_ack)
      begin
        s_d.sda_drv = ~s_q.sh[7];
      end
    end
    // byte stored as the 8th bit is sampled, only when unprotected
    if (scl_r && !s_q.in_ack && s_q.st == T_WDATA && s_q.bitn == 4'h7 && !s_q.wp_s2)
    begin
      mem_we = 1'b1;
    end
    if (stop_c && s_q.st == T_WDATA && s_q.wr_ok)
    begin
      s_d.prog = 1'b1;
    end
    if (s_q.st == T_RDATA && scl_r && !s_q.in_ack)
    begin
      s_d.sh = {s_q.sh[6:0], 1'b0};
    end
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.scl_s <= 2'b11;
      s_q.sda_s <= 2'b11;
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.ptr <= EEPWP_PTR_RESET;
      s_q.st <= T_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// *** src/eepwp_master.sv ***
// two-wire master issuing current, random, sequential reads and writes
`timescale 1ns/100ps
`default_nettype none
module eepwp_master
  (
    input wire logic clk_sys,
    input wire logic rst_b,
    eepwp_if.master bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire eepwp_pkg::eepwp_op_t req_op,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [7:0] req_len,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    output logic done,
    output logic nacked
  );
  import eepwp_pkg::*;

  typedef enum logic [2:0]
  {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BYTE = 3'b010,
    M_ACK = 3'b011,
    M_STOP = 3'b100,
    M_HOLD = 3'b101
  } eepwp_mst_t;

  typedef struct packed
  {
    eepwp_mst_t st;
    logic [1:0] ph;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [1:0] step;
    logic rd;
    eepwp_op_t op;
    logic [7:0] addr;
    logic [7:0] wdat;
    logic [7:0] left;
    logic scl_o;
    logic sda_o;
    logic [1:0] sda_s;
    logic [1:0] bv;
    logic [7:0] b0;
    logic [7:0] b1;
    logic bw;
    logic br;
    logic done;
    logic nack;
    logic rdy;
  } eepwp_mstate_t;

  eepwp_mstate_t s_q, s_d;
  logic tick;
  logic room;

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = ~s_q.scl_o;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = ~s_q.sda_o;
  assign req_ready = s_q.rdy;
  assign rd_valid = s_q.bv[s_q.br];
  assign rd_data = s_q.br ? s_q.b1 : s_q.b0;
  assign done = s_q.done;
  assign nacked = s_q.nack;

  // quarter-bit sequencer with two-entry read buffer
  always_comb
  begin
    s_d = s_q;
    s_d.sda_s = {s_q.sda_s[0], bus.sda};
    s_d.done = 1'b0;
    s_d.rdy = (s_q.st == M_IDLE); // level while idle, so a held request is never starved
    tick = (s_q.div == 8'(EEPWP_HALF_CYC / 2 - 1));
    s_d.div = tick ? 8'h00 : s_q.div + 8'h01;
    room = ~s_q.bv[s_q.bw];
    if (rd_ready && s_q.bv[s_q.br])
    begin
      s_d.bv[s_q.br] = 1'b0;
      s_d.br = ~s_q.br;
    end
    if (s_q.st == M_IDLE && req_valid && s_q.rdy)
    begin
      s_d.op = req_op;
      s_d.addr = req_addr;
      s_d.wdat = req_wdata;
      s_d.left = req_len;
      s_d.step = 2'b00;
      s_d.nack = 1'b0;
      s_d.rdy = 1'b0;
      s_d.st = M_START;
      s_d.ph = 2'b00;
    end
    else if (tick && s_q.st != M_IDLE)
    begin
      s_d.ph = s_q.ph + 2'b01;
      unique case (s_q.st)
        M_START:
        begin
          // ph0 release both, ph1 sda low, ph2 scl low
          unique case (s_q.ph)
            2'b00:
            begin
              s_d.sda_o = 1'b1;
              s_d.scl_o = 1'b1;
            end
            2'b01: s_d.sda_o = 1'b0;
            2'b10: s_d.scl_o = 1'b0;
            default:
            begin
              s_d.st = M_BYTE;
              s_d.bitn = 4'h0;
              s_d.rd = 1'b0;
              // direction bit selects read only on the final address phase
              s_d.sh = {EEPWP_TARGET_ADDR, (s_q.op == EEPWP_OP_CUR || s_q.step == 2'b10) ?
                EEPWP_DIR_READ : EEPWP_DIR_WRITE};
              s_d.step = (s_q.op == EEPWP_OP_CUR) ? 2'b10 : s_q.step;
            end
          endcase
        end
        M_BYTE, M_ACK:
        begin
          unique case (s_q.ph)
            2'b00:
            begin
              if (s_q.st == M_BYTE)
              begin
                s_d.sda_o = s_q.rd ? 1'b1 : s_q.sh[7];
              end
              else
              begin
                // ack a read byte while more are wanted, else nack
                s_d.sda_o = s_q.rd ? (s_q.left == 8'h01) : 1'b1;
              end
            end
            2'b01: s_d.scl_o = 1'b1;
            2'b10:
            begin
              if (s_q.st == M_BYTE)
              begin
                s_d.sh = {s_q.sh[6:0], s_q.sda_s[1]};
              end
              else if (!s_q.rd && s_q.sda_s[1])
              begin
                s_d.nack = 1'b1;
              end
            end
            default:
            begin
              s_d.scl_o = 1'b0;
              if (s_q.st == M_BYTE && s_q.bitn != 4'h7)
              begin
                s_d.bitn = s_q.bitn + 4'h1;
              end
              else if (s_q.st == M_BYTE)
              begin
                s_d.st = M_ACK;
                if (s_q.rd)
                begin
                  s_d.bv[s_q.bw] = 1'b1;
                  s_d.bw = ~s_q.bw;
                  if (s_q.bw)
                  begin
                    s_d.b1 = s_q.sh;
                  end
                  else
                  begin
                    s_d.b0 = s_q.sh;
                  end
                end
              end
              else if (s_q.nack)
              begin
                s_d.st = M_STOP;
              end
              else
              begin
                s_d.bitn = 4'h0;
                s_d.st = M_BYTE;
                unique case (s_q.step)
                  2'b00:
                  begin
                    s_d.step = 2'b01;
                    s_d.sh = s_q.addr;
                  end
                  2'b01:
                  begin
                    if (s_q.op == EEPWP_OP_RAND)
                    begin
                      s_d.step = 2'b10;
                      s_d.st = M_START;
                      s_d.sda_o = 1'b1;
                    end
                    else
                    begin
                      s_d.step = 2'b11;
                      s_d.sh = s_q.wdat;
                    end
                  end
                  2'b10:
                  begin
                    s_d.step = 2'b11;
                    s_d.rd = 1'b1;
                  end
                  default:
                  begin
                    s_d.left = s_q.left - 8'h01;
                    if (!s_q.rd || s_q.left == 8'h01)
                    begin
                      s_d.st = M_STOP;
                    end
                    else if (!room)
                    begin
                      s_d.st = M_HOLD; // receiver stall holds scl low
                    end
                  end
                endcase
              end
            end
          endcase
        end
        M_HOLD:
        begin
          s_d.ph = 2'b00;
          if (room)
          begin
            s_d.st = M_BYTE;
          end
        end
        M_STOP:
        begin
          unique case (s_q.ph)
            2'b00: s_d.sda_o = 1'b0;
            2'b01: s_d.scl_o = 1'b1;
            2'b10: s_d.sda_o = 1'b1;
            default:
            begin
              s_d.st = M_IDLE;
              s_d.done = 1'b1;
            end
          endcase
        end
        default:
        begin
          s_d.st = M_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.scl_o <= 1'b1;
      s_q.sda_o <= 1'b1;
      s_q.sda_s <= 2'b11;
      s_q.st <= M_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// *** bench/eepwp_asserts.sv ***
// concurrent checks on the two-wire link between target and master
`timescale 1ns/100ps
`default_nettype none
module eepwp_asserts
  (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic wp_pin,
    input wire logic busy_prog
  );
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ==========
  // open-drain drivers only ever pull low
  a_target_pulls_low: assert property (sda_s_oe |-> !sda_s_o)
    else $error("target drives sda high");
  a_master_pulls_low: assert property (sda_m_oe |-> !sda_m_o)
    else $error("master drives sda high");
  a_clock_pulls_low: assert property (scl_oe |-> !scl_o)
    else $error("master drives scl high");
  // ==========
  // target moves data only while the clock is low, else it fakes start or stop
  a_target_data_stable: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("target changed sda while scl high");
  // the ack clock belongs to one party only, so it can be read back
  a_ack_one_driver: assert property (scl |-> !(sda_m_oe && sda_s_oe))
    else $error("both ends drive sda in a high phase");
  a_scl_high_hold: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  a_scl_low_hold: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  // ==========
  // protection: no programming cycle starts, and one that starts ends at stop
  a_protect_no_prog: assert property (wp_pin && $past(wp_pin, 4) |-> !$rose(busy_prog))
    else $error("programming started under protection");
  // flag stands until the next stop, so its length is bounded by a run counter
  localparam int PROG_MAX = 20000;
  int prog_run_q;
  always_ff @(posedge clk_sys)
  begin
    prog_run_q <= (rst_b && busy_prog) ? prog_run_q + 1 : 0;
  end
  a_prog_ends: assert property (prog_run_q < PROG_MAX)
    else $error("programming flag never cleared");
  c_prog: cover property ($rose(busy_prog));
endmodule
`default_nettype wire

// *** bench/eepwp_tb.sv ***
// self-checking bench for the two-wire eeprom target and master
`timescale 1ns/100ps
`default_nettype none
module eepwp_tb;
  import eepwp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic wp_pin = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  eepwp_op_t req_op = EEPWP_OP_CUR;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] req_len = 8'h01;
  logic rd_valid;
  logic rd_ready = 1'b0;
  logic [7:0] rd_data;
  logic done;
  logic nacked;
  logic busy_prog;
  logic prog_seen = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  int done_cnt = 0;
  int mem [256];
  int ptr = 0;
  logic [7:0] got [$];
  // ==========
  // the two ends face each other across one interface
  eepwp_if bus_if ();
  eepwp_target eepwp_target_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus_if.target),
    .wp_pin(wp_pin), .busy_prog(busy_prog));
  eepwp_master eepwp_master_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus_if.master),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_len(req_len), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .done(done), .nacked(nacked));
  eepwp_asserts eepwp_asserts_i (.clk_sys(clk_sys), .rst_b(rst_b), .scl(bus_if.scl),
    .sda(bus_if.sda), .scl_o(bus_if.scl_o), .scl_oe(bus_if.scl_oe),
    .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe), .sda_s_o(bus_if.sda_s_o),
    .sda_s_oe(bus_if.sda_s_oe), .wp_pin(wp_pin), .busy_prog(busy_prog));
  // ==========
  // clock, monitor and receiver stalls
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (rd_valid === 1'b1 && rd_ready) got.push_back(rd_data);
    if (done === 1'b1) done_cnt++;
    if (busy_prog === 1'b1) prog_seen = 1'b1;
  end
  // stalls drop rd_ready with one chance in four per clock, too briefly to fill the two-entry buffer, so the master never holds the clock low
  always @(negedge clk_sys) rd_ready <= ($urandom % 4) != 0;
  // ==========
  // verdict and comparison helpers
  task automatic report_and_stop();
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one request, held until taken, then wait for stop and all read bytes
  task automatic run(input eepwp_op_t op, input int a, input int d, input int n);
    int w;
    int c;
    @(negedge clk_sys);
    got.delete();
    prog_seen = 1'b0;
    c = done_cnt;
    req_op = op;
    req_addr = a[7:0];
    req_wdata = d[7:0];
    req_len = (n > 0) ? n[7:0] : 8'h01;
    req_valid = 1'b1;
    w = 0;
    while (req_ready !== 1'b1 && w < 1000)
    begin
      @(negedge clk_sys);
      w++;
    end
    chk("req_ready", 8'h01, {7'h00, req_ready === 1'b1});
    @(negedge clk_sys);
    req_valid = 1'b0;
    w = 0;
    while ((done_cnt == c || got.size() < n) && w < 20000)
    begin
      @(negedge clk_sys);
      w++;
    end
    chk("done", 8'h01, (done_cnt != c) ? 8'h01 : 8'h00);
  endtask
  task automatic wr(input int a, input int d);
    run(EEPWP_OP_WRITE, a, d, 0);
    if (wp_pin)
    begin
      chk("nacked", 8'h01, {7'h00, nacked});
      chk("prog", 8'h00, {7'h00, prog_seen});
      // refused byte leaves the counter on the loaded address
      ptr = a % 256;
    end
    else
    begin
      mem[a] = d;
      ptr = (a + 1) % 256;
      chk("nacked", 8'h00, {7'h00, nacked});
      chk("prog", 8'h01, {7'h00, prog_seen});
    end
  endtask
  // model: bytes stream from the base, wrapping across all eight bits
  task automatic rd(input eepwp_op_t op, input int a, input int n);
    int b;
    run(op, a, 0, n);
    b = (op == EEPWP_OP_CUR) ? ptr : a;
    for (int i = 0; i < n; i++)
      chk("rd_data", 8'(mem[(b + i) % 256]), got[i]);
    chk("rd_count", 8'(n), 8'(got.size()));
    chk("nacked", 8'h00, {7'h00, nacked});
    ptr = (b + n) % 256;
  endtask
  // ==========
  // main sequence
  initial
  begin
    int o;
    void'($urandom(27));
    for (int i = 0; i < 256; i++) mem[i] = 0;
    repeat (16) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    // bytes around the wrap point, FE last so the counter sits at FF
    for (int i = 0; i < 6; i++)
      wr((i == 5) ? 254 : (255 + i) % 256, $urandom % 256);
    rd(EEPWP_OP_CUR, 0, 3);
    rd(EEPWP_OP_RAND, 254, 4);
    rd(EEPWP_OP_CUR, 0, 2);
    wp_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    wr(1, mem[1] ^ 255);
    rd(EEPWP_OP_RAND, 1, 1);
    wp_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int k = 0; k < 3; k++)
    begin
      o = $urandom % 6;
      rd(EEPWP_OP_RAND, (254 + o) % 256, 1 + $urandom % (6 - o));
    end
    report_and_stop();
  end
  // watchdog well beyond the expected run length
  initial
  begin
    #(100000 * 25);
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
